// ---- core/t16_defs.svh ----
`ifndef T16_DEFS_SVH
`define T16_DEFS_SVH
// ***********************************************
// Register offsets on the 8-bit register port
// ***********************************************
`define T16_OFS_CNT_LO   4'h0
`define T16_OFS_CNT_HI   4'h1
`define T16_OFS_CAP_LO   4'h2
`define T16_OFS_CAP_HI   4'h3
`define T16_OFS_CTRL_A   4'h4
`define T16_OFS_CTRL_B   4'h5
`define T16_OFS_FLAGS    4'h6
`define T16_OFS_MASK     4'h7
`define T16_OFS_CMP_CS   4'h8
// ***********************************************
// Field positions
// ***********************************************
`define T16_B_NOISE_EN   7
`define T16_B_EDGE_SEL   6
`define T16_B_WGM_HI     4
`define T16_B_WGM_LO     3
`define T16_B_CS_HI      2
`define T16_B_CAP_FLAG   5
`define T16_B_OVF_FLAG   0
`define T16_B_CMP_SEL    2
// ***********************************************
// Reset values and fixed counts
// ***********************************************
`define T16_RST_BYTE     8'h00
`define T16_RST_WORD     16'h0000
`define T16_BOTTOM       16'h0000
`define T16_MAX          16'hFFFF
`define T16_TOP_8BIT     16'h00FF
`define T16_TOP_9BIT     16'h01FF
`define T16_TOP_10BIT    16'h03FF
`define T16_FILTER_LEN   4
`endif

// ---- core/t16_pkg.sv ----
package t16_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } t16_bus_req_type;

   typedef struct packed {
      logic irq_capture;
      logic irq_overflow;
   } t16_irq_type;

   typedef enum logic {
      T16_UP   = 1'b0,
      T16_DOWN = 1'b1
   } t16_dir_type;
endpackage : t16_pkg

// ---- core/t16_timer.sv ----
// Behaviour
// - High-byte access uses holding register; low read loads
// - Counter low write loads all sixteen bits
// - Counter clears, increments or decrements per tick
// - Clock select zero stops; counter stays accessible
// - CPU counter write beats clear or count
// - Four-bit waveform mode field sets counting sequence
// - Overflow flag set per mode; interrupts when enabled
// - Selected capture edge copies counter to capture
// - Capture flag set in same cycle as copy
// - Enabled capture flag interrupts; cleared on service
// - Writing one clears capture flag
// - Capture low read loads holding register
// - Capture writable only in capture-top modes
// - Comparator select bit switches capture source
// - Inputs synchronised; filter adds four cycles
// - Capture events off in capture-top modes; filter still runs
// - Filter changes after four agreeing samples
// - Filter enable bit; filter runs on system clock
// - Port-driven capture pin also captures
// - Bottom zero, max all ones, top per mode
`include "t16_defs.svh"

module t16_timer (
   input  wire logic                   CLK_SYS,
   input  wire logic                   RST_B,
   input  wire t16_pkg::t16_bus_req_type BUS_REQ,
   input  wire logic                   ACK_CAPTURE,
   input  wire logic                   ACK_OVERFLOW,
   input  wire logic                   CAPTURE_PIN,
   input  wire logic                   COMPARATOR_OUTPUT,
   input  wire logic                   EXTERNAL_CLOCK_PIN,
   output logic [7:0]                  RDATA,
   output t16_pkg::t16_irq_type        IRQ
);
   import t16_pkg::*;

   // ***********************************************
   // State
   // ***********************************************
   logic [15:0] count_value;
   logic [15:0] next_count_value;
   logic [15:0] capture_value;
   logic [15:0] next_capture_value;
   logic [7:0]  hold_byte;
   logic [7:0]  next_hold_byte;
   logic [7:0]  control_reg_a;
   logic [7:0]  next_control_reg_a;
   logic [7:0]  control_reg_b;
   logic [7:0]  next_control_reg_b;
   logic        capture_irq_enable;
   logic        next_capture_irq_enable;
   logic        overflow_irq_enable;
   logic        next_overflow_irq_enable;
   logic        comparator_capture_select;
   logic        next_comparator_capture_select;
   logic        capture_flag;
   logic        next_capture_flag;
   logic        overflow_flag;
   logic        next_overflow_flag;
   t16_dir_type dir;
   t16_dir_type next_dir;
   logic [9:0]  prescale;
   logic [9:0]  next_prescale;
   logic [7:0]  next_rdata;
   t16_irq_type next_irq;

   // Input synchronisers and capture path
   logic        pin_meta;
   logic        pin_sync;
   logic        cmp_meta;
   logic        cmp_sync;
   logic        ext_meta;
   logic        ext_sync;
   logic        ext_prev;
   logic [3:0]  filt_hist;
   logic [3:0]  next_filt_hist;
   logic        filt_out;
   logic        next_filt_out;
   logic        edge_prev;
   logic        next_edge_prev;

   // Decoded controls
   logic [3:0]  waveform_mode_field;
   logic [2:0]  clock_select_field;
   logic        noise_filter_enable;
   logic        edge_select;
   logic [15:0] top_value;
   logic        dual_slope;
   logic        top_flags;
   logic        cap_top_mode;
   logic        timer_tick;
   logic        cap_src;
   logic        edge_in;
   logic        capture_event;
   logic        ovf_set;
   logic        wr_cnt_lo;
   logic        wr_cap_lo;
   logic        bus_wr;
   logic        bus_rd;

   assign bus_wr = BUS_REQ.wr;
   assign bus_rd = BUS_REQ.rd;
   assign waveform_mode_field = {control_reg_b[`T16_B_WGM_HI:`T16_B_WGM_LO],
                                 control_reg_a[1:0]};
   assign clock_select_field  = control_reg_b[`T16_B_CS_HI:0];
   assign noise_filter_enable = control_reg_b[`T16_B_NOISE_EN];
   assign edge_select         = control_reg_b[`T16_B_EDGE_SEL];
   assign wr_cnt_lo = bus_wr && (BUS_REQ.addr == `T16_OFS_CNT_LO);
   assign wr_cap_lo = bus_wr && (BUS_REQ.addr == `T16_OFS_CAP_LO);

   // ***********************************************
   // Mode decode: top value, slope and overflow point
   // ***********************************************
   always_comb begin
      top_value    = `T16_MAX;
      dual_slope   = 1'b0;
      top_flags    = 1'b0;
      cap_top_mode = 1'b0;
      case (waveform_mode_field)
         4'h1: begin
            top_value  = `T16_TOP_8BIT;
            dual_slope = 1'b1;
         end
         4'h2: begin
            top_value  = `T16_TOP_9BIT;
            dual_slope = 1'b1;
         end
         4'h3: begin
            top_value  = `T16_TOP_10BIT;
            dual_slope = 1'b1;
         end
         4'h5: begin
            top_value = `T16_TOP_8BIT;
            top_flags = 1'b1;
         end
         4'h6: begin
            top_value = `T16_TOP_9BIT;
            top_flags = 1'b1;
         end
         4'h7: begin
            top_value = `T16_TOP_10BIT;
            top_flags = 1'b1;
         end
         4'h8, 4'hA: begin
            top_value    = capture_value;
            dual_slope   = 1'b1;
            cap_top_mode = 1'b1;
         end
         4'hC: begin
            top_value    = capture_value;
            cap_top_mode = 1'b1;
         end
         4'hE: begin
            top_value    = capture_value;
            top_flags    = 1'b1;
            cap_top_mode = 1'b1;
         end
         4'h9, 4'hB: begin
            dual_slope = 1'b1;
         end
         4'hF: begin
            top_flags = 1'b1;
         end
         default: begin
            top_value = `T16_MAX;
         end
      endcase
   end

   // ***********************************************
   // Timer tick from clock select
   // ***********************************************
   always_comb begin
      next_prescale = prescale + 10'h001;
      case (clock_select_field)
         3'h0:    timer_tick = 1'b0;
         3'h1:    timer_tick = 1'b1;
         3'h2:    timer_tick = (prescale[2:0] == 3'h7);
         3'h3:    timer_tick = (prescale[5:0] == 6'h3F);
         3'h4:    timer_tick = (prescale[7:0] == 8'hFF);
         3'h5:    timer_tick = (prescale == 10'h3FF);
         3'h6:    timer_tick = ext_prev && !ext_sync;
         default: timer_tick = !ext_prev && ext_sync;
      endcase
   end

   // ***********************************************
   // Capture source, noise filter, edge detector
   // ***********************************************
   always_comb begin
      cap_src = comparator_capture_select ? cmp_sync : pin_sync;
      next_filt_hist = {filt_hist[2:0], cap_src};
      next_filt_out  = filt_out;
      if (next_filt_hist == {`T16_FILTER_LEN{!filt_out}}) begin
         next_filt_out = !filt_out;
      end
      edge_in = noise_filter_enable ? filt_out : cap_src;
      next_edge_prev = edge_in;
      capture_event = 1'b0;
      if (!cap_top_mode) begin
         // Port-driven pin level arrives here like any edge
         capture_event = edge_select ? (edge_in && !edge_prev)
                                     : (!edge_in && edge_prev);
      end
   end

   // ***********************************************
   // Counter, capture and register file
   // ***********************************************
   always_comb begin
      next_count_value   = count_value;
      next_dir           = dir;
      next_capture_value = capture_value;
      next_hold_byte     = hold_byte;
      next_control_reg_a = control_reg_a;
      next_control_reg_b = control_reg_b;
      next_capture_irq_enable        = capture_irq_enable;
      next_overflow_irq_enable       = overflow_irq_enable;
      next_comparator_capture_select = comparator_capture_select;
      next_capture_flag  = capture_flag;
      next_overflow_flag = overflow_flag;
      next_rdata         = RDATA;
      ovf_set            = 1'b0;

      // Flag clears first so that a same-cycle set wins
      if (ACK_CAPTURE) begin
         next_capture_flag = 1'b0;
      end
      if (ACK_OVERFLOW) begin
         next_overflow_flag = 1'b0;
      end

      if (timer_tick) begin
         if (dual_slope) begin
            if (dir == T16_UP) begin
               if (count_value >= top_value) begin
                  next_dir         = T16_DOWN;
                  next_count_value = count_value - 16'h0001;
               end else begin
                  next_count_value = count_value + 16'h0001;
               end
            end else begin
               if (count_value == `T16_BOTTOM) begin
                  next_dir           = T16_UP;
                  next_count_value   = count_value + 16'h0001;
                  ovf_set            = 1'b1;
                  next_overflow_flag = 1'b1;
               end else begin
                  next_count_value = count_value - 16'h0001;
               end
            end
         end else begin
            next_dir = T16_UP;
            if (count_value >= top_value) begin
               next_count_value = `T16_BOTTOM;
               if (top_flags || count_value == `T16_MAX) begin
                  ovf_set            = 1'b1;
                  next_overflow_flag = 1'b1;
               end
            end else begin
               next_count_value = count_value + 16'h0001;
            end
         end
      end

      if (capture_event) begin
         next_capture_value = count_value;
         next_capture_flag  = 1'b1;
      end

      if (bus_rd) begin
         case (BUS_REQ.addr)
            `T16_OFS_CNT_LO: begin
               next_rdata     = count_value[7:0];
               next_hold_byte = count_value[15:8];
            end
            `T16_OFS_CAP_LO: begin
               next_rdata     = capture_value[7:0];
               next_hold_byte = capture_value[15:8];
            end
            `T16_OFS_CNT_HI, `T16_OFS_CAP_HI: begin
               next_rdata = hold_byte;
            end
            `T16_OFS_CTRL_A: next_rdata = control_reg_a;
            `T16_OFS_CTRL_B: next_rdata = control_reg_b;
            `T16_OFS_FLAGS: begin
               next_rdata = `T16_RST_BYTE;
               next_rdata[`T16_B_CAP_FLAG] = capture_flag;
               next_rdata[`T16_B_OVF_FLAG] = overflow_flag;
            end
            `T16_OFS_MASK: begin
               next_rdata = `T16_RST_BYTE;
               next_rdata[`T16_B_CAP_FLAG] = capture_irq_enable;
               next_rdata[`T16_B_OVF_FLAG] = overflow_irq_enable;
            end
            `T16_OFS_CMP_CS: begin
               next_rdata = `T16_RST_BYTE;
               next_rdata[`T16_B_CMP_SEL] = comparator_capture_select;
            end
            default: next_rdata = `T16_RST_BYTE;
         endcase
      end

      if (bus_wr) begin
         case (BUS_REQ.addr)
            `T16_OFS_CNT_HI, `T16_OFS_CAP_HI: begin
               next_hold_byte = BUS_REQ.wdata;
            end
            `T16_OFS_CTRL_A: next_control_reg_a = BUS_REQ.wdata;
            `T16_OFS_CTRL_B: next_control_reg_b = BUS_REQ.wdata;
            `T16_OFS_FLAGS: begin
               if (BUS_REQ.wdata[`T16_B_CAP_FLAG] && !capture_event) begin
                  next_capture_flag = 1'b0;
               end
               // A set in the same cycle wins over the clear
               if (BUS_REQ.wdata[`T16_B_OVF_FLAG] && !ovf_set) begin
                  next_overflow_flag = 1'b0;
               end
            end
            `T16_OFS_MASK: begin
               next_capture_irq_enable  = BUS_REQ.wdata[`T16_B_CAP_FLAG];
               next_overflow_irq_enable = BUS_REQ.wdata[`T16_B_OVF_FLAG];
            end
            `T16_OFS_CMP_CS: begin
               next_comparator_capture_select =
                  BUS_REQ.wdata[`T16_B_CMP_SEL];
            end
            default: begin
               next_hold_byte = hold_byte;
            end
         endcase
      end

      if (wr_cnt_lo) begin
         // Overrides any clear or count computed above
         next_count_value = {hold_byte, BUS_REQ.wdata};
      end
      if (wr_cap_lo && cap_top_mode) begin
         next_capture_value = {hold_byte, BUS_REQ.wdata};
      end

      next_irq.irq_capture  = next_capture_flag
                              && next_capture_irq_enable;
      next_irq.irq_overflow = next_overflow_flag
                              && next_overflow_irq_enable;
   end

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         pin_meta  <= 1'b0;
         pin_sync  <= 1'b0;
         cmp_meta  <= 1'b0;
         cmp_sync  <= 1'b0;
         ext_meta  <= 1'b0;
         ext_sync  <= 1'b0;
         ext_prev  <= 1'b0;
         filt_hist <= 4'h0;
         filt_out  <= 1'b0;
         edge_prev <= 1'b0;
         prescale  <= 10'h000;
         count_value   <= `T16_RST_WORD;
         capture_value <= `T16_RST_WORD;
         hold_byte     <= `T16_RST_BYTE;
         control_reg_a <= `T16_RST_BYTE;
         control_reg_b <= `T16_RST_BYTE;
         dir           <= T16_UP;
         capture_irq_enable        <= 1'b0;
         overflow_irq_enable       <= 1'b0;
         comparator_capture_select <= 1'b0;
         capture_flag  <= 1'b0;
         overflow_flag <= 1'b0;
         RDATA         <= `T16_RST_BYTE;
         IRQ           <= '0;
      end else begin
         pin_meta  <= CAPTURE_PIN;
         pin_sync  <= pin_meta;
         cmp_meta  <= COMPARATOR_OUTPUT;
         cmp_sync  <= cmp_meta;
         ext_meta  <= EXTERNAL_CLOCK_PIN;
         ext_sync  <= ext_meta;
         ext_prev  <= ext_sync;
         filt_hist <= next_filt_hist;
         filt_out  <= next_filt_out;
         edge_prev <= next_edge_prev;
         prescale  <= next_prescale;
         count_value   <= next_count_value;
         capture_value <= next_capture_value;
         hold_byte     <= next_hold_byte;
         control_reg_a <= next_control_reg_a;
         control_reg_b <= next_control_reg_b;
         dir           <= next_dir;
         capture_irq_enable        <= next_capture_irq_enable;
         overflow_irq_enable       <= next_overflow_irq_enable;
         comparator_capture_select <= next_comparator_capture_select;
         capture_flag  <= next_capture_flag;
         overflow_flag <= next_overflow_flag;
         RDATA         <= next_rdata;
         IRQ           <= next_irq;
      end
   end
endmodule : t16_timer

// ---- verif/t16_timer_checker.sv ----
module t16_timer_checker (
   input wire logic                     CLK_SYS,
   input wire logic                     RST_B,
   input wire t16_pkg::t16_bus_req_type BUS_REQ,
   input wire logic                     ACK_CAPTURE,
   input wire logic                     ACK_OVERFLOW,
   input wire logic                     CAPTURE_PIN,
   input wire logic                     COMPARATOR_OUTPUT,
   input wire logic                     EXTERNAL_CLOCK_PIN,
   input wire logic [7:0]               RDATA,
   input wire t16_pkg::t16_irq_type     IRQ
);
   import t16_pkg::*;
   // ****************************************
   // Port relations
   // ****************************************
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   reset_quiet_a: assert property (
      $rose(RST_B) |-> RDATA == 8'h00 && IRQ == 2'h0)
      else $error("outputs not quiet after reset");
   rdata_hold_a: assert property (
      !BUS_REQ.rd |=> $stable(RDATA))
      else $error("read data moved without a read");
   unmapped_read_a: assert property (
      BUS_REQ.rd && BUS_REQ.addr > 4'h8 |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   hold_read_a: assert property (
      BUS_REQ.wr && BUS_REQ.addr inside {4'h1, 4'h3} ##1
      BUS_REQ.rd && BUS_REQ.addr inside {4'h1, 4'h3}
      |=> RDATA == $past(BUS_REQ.wdata, 2))
      else $error("high byte read not from holding byte");
   ack_capture_a: assert property (
      ACK_CAPTURE |-> ##[1:2] !IRQ.irq_capture)
      else $error("capture irq survived service");
   ack_overflow_a: assert property (
      ACK_OVERFLOW |-> ##[1:2] !IRQ.irq_overflow)
      else $error("overflow irq survived service");
   sw_clear_a: assert property (
      BUS_REQ.wr && BUS_REQ.addr == 4'h6 && BUS_REQ.wdata[5]
      |-> ##[1:2] !IRQ.irq_capture)
      else $error("capture irq survived write one");
   mask_off_a: assert property (
      BUS_REQ.wr && BUS_REQ.addr == 4'h7 && !BUS_REQ.wdata[0]
      |-> ##[1:2] !IRQ.irq_overflow)
      else $error("overflow irq survived mask");
endmodule : t16_timer_checker

bind t16_timer t16_timer_checker t16_timer_checker_i (
   .CLK_SYS(CLK_SYS), .RST_B(RST_B), .BUS_REQ(BUS_REQ),
   .ACK_CAPTURE(ACK_CAPTURE), .ACK_OVERFLOW(ACK_OVERFLOW),
   .CAPTURE_PIN(CAPTURE_PIN), .COMPARATOR_OUTPUT(COMPARATOR_OUTPUT),
   .EXTERNAL_CLOCK_PIN(EXTERNAL_CLOCK_PIN), .RDATA(RDATA), .IRQ(IRQ));

// ---- verif/t16_cpu_model.sv ----
module t16_cpu_model (
   input  wire logic                CLK_SYS,
   input  wire logic [7:0]          RDATA,
   output t16_pkg::t16_bus_req_type BUS_REQ,
   output logic                     ACK_CAPTURE,
   output logic                     ACK_OVERFLOW
);
   timeunit 1ns;
   timeprecision 1ns;
   import t16_pkg::*;
   // ****************************************
   // Bus cycles, one edge each
   // ****************************************
   initial begin
      BUS_REQ = '0;
      ACK_CAPTURE = 1'b0;
      ACK_OVERFLOW = 1'b0;
   end
   task automatic xfer(input logic [3:0] a, input logic [7:0] d,
                       input logic w);
      BUS_REQ <= '{a, d, w, !w};
      @(posedge CLK_SYS);
      BUS_REQ <= '0;
      #1;
   endtask : xfer
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      xfer(a, 8'h00, 1'b0);
      d = RDATA;
   endtask : rd
   // Pairs run whole, never split by other traffic
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      xfer(lo + 4'h1, v[15:8], 1'b1);
      xfer(lo, v[7:0], 1'b1);
   endtask : wr16
   task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 4'h1, v[15:8]);
   endtask : rd16
   task automatic ack(input logic ovf);
      if (ovf) ACK_OVERFLOW <= 1'b1;
      else ACK_CAPTURE <= 1'b1;
      @(posedge CLK_SYS);
      ACK_OVERFLOW <= 1'b0;
      ACK_CAPTURE <= 1'b0;
      #1;
   endtask : ack
endmodule : t16_cpu_model

// ---- verif/t16_timer_bench.sv ----
module t16_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import t16_pkg::*;
   logic            CLK_SYS;
   logic            RST_B = 1'b0;
   t16_bus_req_type BUS_REQ;
   logic            ACK_CAPTURE, ACK_OVERFLOW;
   logic            CAPTURE_PIN = 1'b0;
   logic            COMPARATOR_OUTPUT = 1'b0;
   logic            EXTERNAL_CLOCK_PIN = 1'b0;
   logic [7:0]      RDATA, b;
   t16_irq_type     IRQ;
   logic [15:0]     w;
   int              fail_count = 0, compares = 0, cycles = 0, n, nu;
   t16_timer t16_timer_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
      .BUS_REQ(BUS_REQ), .ACK_CAPTURE(ACK_CAPTURE),
      .ACK_OVERFLOW(ACK_OVERFLOW), .CAPTURE_PIN(CAPTURE_PIN),
      .COMPARATOR_OUTPUT(COMPARATOR_OUTPUT),
      .EXTERNAL_CLOCK_PIN(EXTERNAL_CLOCK_PIN), .RDATA(RDATA), .IRQ(IRQ));
   t16_cpu_model t16_cpu_model_i (.CLK_SYS(CLK_SYS), .RDATA(RDATA),
      .BUS_REQ(BUS_REQ), .ACK_CAPTURE(ACK_CAPTURE),
      .ACK_OVERFLOW(ACK_OVERFLOW));
   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   initial begin
      CLK_SYS = 1'b0;
      forever #50 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      t16_cpu_model_i.xfer(a, d, 1'b1);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      t16_cpu_model_i.rd(a, b);
   endtask : rd
   task automatic idle(input int k);
      repeat (k) @(posedge CLK_SYS);
      #1;
   endtask : idle
   task automatic drive(input logic cmp, input logic v);
      @(posedge CLK_SYS);
      if (cmp) COMPARATOR_OUTPUT <= v;
      else CAPTURE_PIN <= v;
      #1;
   endtask : drive
   task automatic wait_irq(input logic ovf);
      n = 0;
      while ((ovf ? IRQ.irq_overflow : IRQ.irq_capture) !== 1'b1
             && n < 30) begin
         @(posedge CLK_SYS);
         #1;
         n++;
      end
   endtask : wait_irq
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      for (int a = 0; a < 10; a++) begin
         rd(a[3:0]);
         chk(b, 8'h00);
      end
   endtask : t_reset
   task automatic t_count;
      t16_cpu_model_i.wr16(4'h0, 16'h1234);
      t16_cpu_model_i.rd16(4'h0, w);
      chk(w, 16'h1234);
      wr(4'h5, 8'h01);
      t16_cpu_model_i.wr16(4'h0, 16'hABCD);
      rd(4'h0);
      chk(b, 8'hCD);
      rd(4'h0);
      chk(b, 8'hCE);
      wr(4'h5, 8'h00);
      wr(4'h3, 8'h77);
      rd(4'h1);
      chk(b, 8'h77);
      wr(4'h0, 8'h11);
      t16_cpu_model_i.rd16(4'h0, w);
      chk(w, 16'h7711);
   endtask : t_count
   task automatic t_overflow;
      wr(4'h7, 8'h01);
      t16_cpu_model_i.wr16(4'h0, 16'hFFFE);
      wr(4'h5, 8'h01);
      wait_irq(1'b1);
      chk(16'(n < 30), 16'h0001);
      wr(4'h5, 8'h00);
      t16_cpu_model_i.ack(1'b1);
      idle(2);
      chk(IRQ.irq_overflow, 1'b0);
      wr(4'h7, 8'h20);
      wr(4'h4, 8'h01);
      t16_cpu_model_i.wr16(4'h0, 16'h00FE);
      wr(4'h5, 8'h09);
      idle(4);
      wr(4'h5, 8'h08);
      t16_cpu_model_i.rd16(4'h0, w);
      chk(w[15:8], 8'h00);
      rd(4'h6);
      chk(b[0], 1'b1);
      wr(4'h6, 8'h01);
      wr(4'h4, 8'h00);
   endtask : t_overflow
   task automatic t_capture;
      t16_cpu_model_i.wr16(4'h0, 16'h5A3C);
      wr(4'h5, 8'h40);
      drive(1'b0, 1'b1);
      wait_irq(1'b0);
      nu = n;
      chk(16'(n < 30), 16'h0001);
      rd(4'h6);
      chk(b[5], 1'b1);
      t16_cpu_model_i.rd16(4'h2, w);
      chk(w, 16'h5A3C);
      wr(4'h6, 8'h20);
      drive(1'b0, 1'b0);
      idle(12);
      chk(IRQ.irq_capture, 1'b0);
      wr(4'h5, 8'hC0);
      drive(1'b0, 1'b1);
      idle(2);
      drive(1'b0, 1'b0);
      idle(12);
      chk(IRQ.irq_capture, 1'b0);
      drive(1'b0, 1'b1);
      wait_irq(1'b0);
      chk(16'(n), 16'(nu + 4));
      t16_cpu_model_i.ack(1'b0);
      idle(2);
      chk(IRQ.irq_capture, 1'b0);
   endtask : t_capture
   task automatic t_source;
      wr(4'h5, 8'h40);
      wr(4'h8, 8'h04);
      wr(4'h6, 8'h20);
      drive(1'b0, 1'b0);
      idle(6);
      drive(1'b0, 1'b1);
      idle(12);
      chk(IRQ.irq_capture, 1'b0);
      drive(1'b1, 1'b1);
      wait_irq(1'b0);
      chk(16'(n), 16'(nu));
      wr(4'h8, 8'h00);
      idle(2);
      wr(4'h6, 8'h20);
      wr(4'h5, 8'h58);
      t16_cpu_model_i.wr16(4'h2, 16'h1357);
      t16_cpu_model_i.rd16(4'h2, w);
      chk(w, 16'h1357);
      drive(1'b0, 1'b0);
      idle(6);
      drive(1'b0, 1'b1);
      idle(6);
      drive(1'b0, 1'b0);
      idle(12);
      chk(IRQ.irq_capture, 1'b0);
      wr(4'h5, 8'h40);
      t16_cpu_model_i.wr16(4'h2, 16'h2468);
      t16_cpu_model_i.rd16(4'h2, w);
      chk(w, 16'h1357);
   endtask : t_source
   initial begin
      repeat (3) @(posedge CLK_SYS);
      RST_B <= 1'b1;
      #1;
      t_reset();
      t_count();
      t_overflow();
      t_capture();
      t_source();
      finish_test();
   end
endmodule : t16_timer_bench
